//--- hdl/edge_counter_pkg.sv
// shared constants and types for the rising-edge event counter pair
package edge_counter_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] CNT_A_BASE = 8'h00;
    localparam logic [7:0] CNT_B_BASE = 8'h20;
    localparam logic [7:0] CNT_OFF_MASK = 8'h1F;
    localparam int CNT_SEL_BIT = 5;
    localparam logic [7:0] OFF_FUNC = 8'h00;
    localparam logic [7:0] OFF_SRC = 8'h04;
    localparam logic [7:0] OFF_LIMIT = 8'h08;
    localparam logic [7:0] OFF_DIV = 8'h0C;
    localparam logic [7:0] OFF_CHOICE = 8'h10;
    localparam logic [7:0] OFF_VALUE = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h40;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h44;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h48;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h4C;

    // ----------------------------------------------------------------
    // fields
    // ----------------------------------------------------------------
    localparam int FUNC_LATCH_BIT = 0;
    localparam int FUNC_ENABLE_BIT = 1;
    localparam int SRC_PTR_LSB = 8;
    localparam int STATUS_EXCEEDED_A_BIT = 2;
    localparam int STATUS_EXCEEDED_B_BIT = 3;
    localparam int STATUS_ALARM_A_BIT = 0;
    localparam int STATUS_ALARM_B_BIT = 1;

    // source select codes, bits [2:0] of the source register
    localparam logic [2:0] SRC_RELAY_ONE = 3'h0;
    localparam logic [2:0] SRC_RUNNING = 3'h1;
    localparam logic [2:0] SRC_CHARGED = 3'h2;
    localparam logic [2:0] SRC_CONST_LOW = 3'h3;
    localparam logic [2:0] SRC_CONST_HIGH = 3'h4;
    localparam logic [2:0] SRC_POINTER = 3'h5;

    // alarm identities
    localparam logic [2:0] ALARM_EDGE_COUNT = 3'h0;
    localparam logic [2:0] ALARM_MAIN_CONTACTOR = 3'h1;
    localparam logic [2:0] ALARM_OUTPUT_RELAY = 3'h2;
    localparam logic [2:0] ALARM_MOTOR_STARTS = 3'h3;
    localparam logic [2:0] ALARM_POWER_UPS = 3'h4;
    localparam logic [2:0] ALARM_LINK_CHARGE = 3'h5;

    // ----------------------------------------------------------------
    // reset values and timing
    // ----------------------------------------------------------------
    localparam logic [1:0] FUNC_RESET = 2'h0;
    localparam logic [12:0] SRC_RESET = 13'h0000;
    localparam logic [30:0] LIMIT_RESET = 31'h7FFFFFFF;
    localparam logic [30:0] DIV_RESET = 31'h00000001;
    localparam logic [30:0] DIV_MIN = 31'h00000001;
    localparam int ALARM_HOLD_S = 10;
    localparam longint CLK_HZ_DEFAULT = 100000000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ALARM_IDLE = 3'h1,
        ALARM_TIMED = 3'h2,
        ALARM_LATCHED = 3'h4
    } alarm_state_t;

endpackage

//--- hdl/rising_edge_event_counter.sv
// two rising-edge event counters with alarms behind an AXI4-Lite slave
//
// What this block does
// R1 - every rising edge of each counter's selected bit is a count event.
// R2 - the count moves by one only after divisor edges; divisor is at least 1.
// R3 - at the limit the enabled alarm is raised and the count returns to 0.
// R4 - the alarm limit is unsigned, from 0 up to 2147483647.
// R5 - the alarm choice picks one of six alarm identities, codes 0 to 5.
// R6 - software reads the count, and a write to the count clears it.
// R7 - counter status bit 3 flags that counter b has passed its limit.
// R8 - function-word bit 1 enables the alarm; when clear no alarm is raised.
// R9 - function bit 0 clear holds the alarm 10 s; set latches it until reset.
// R10 - the source may also be any bit by pointer, or a constant value.
// R11 - counter status bit 2 flags that counter a has passed its limit.
// R12 - sources include relay one state, drive running and circuit charged.
// R13 - the watched bit is registered; low then high is a rising edge.
// R14 - the 10 s hold is a cycle count derived from the clock frequency.
`timescale 1ns/1ps
`default_nettype none

module rising_edge_event_counter #(
    parameter int PTR_W = 5,
    parameter longint CLK_HZ = edge_counter_pkg::CLK_HZ_DEFAULT,
    parameter longint ALARM_HOLD_CYCLES =
        longint'(edge_counter_pkg::ALARM_HOLD_S) * CLK_HZ // [R14]
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic relay_one_state,
    input wire logic drive_running,
    input wire logic circuit_charged,
    input wire logic [(1<<PTR_W)-1:0] monitored_bits,
    output logic alarm_a_active,
    output logic [2:0] alarm_a_id,
    output logic alarm_b_active,
    output logic [2:0] alarm_b_id,
    output logic irq
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0][1:0] func;
        logic [1:0][12:0] src;
        logic [1:0][30:0] limit;
        logic [1:0][30:0] divisor;
        logic [1:0][2:0] choice;
        logic [1:0][31:0] value;
        logic [1:0][30:0] prescale;
        logic [1:0] sample;
        logic [1:0] prev;
        logic [1:0] exceeded;
        edge_counter_pkg::alarm_state_t [1:0] alarm_state;
        logic [1:0] alarm_out;
        logic [1:0][2:0] alarm_id;
        logic [1:0][31:0] hold;
        logic [1:0] irq_status;
        logic [1:0] irq_enable;
        logic irq;
        logic aw_full;
        logic [7:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } state_t;

    localparam logic [31:0] HOLD_LOAD = 32'(ALARM_HOLD_CYCLES - 1); // [R14]

    state_t s;
    state_t next_s;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_word,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_word;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = data[8*b +: 8];
            end
        end
        return res;
    endfunction

    // true when one more step makes cnt reach target
    function automatic logic reaches(
        input logic [31:0] cnt,
        input logic [31:0] target
    );
        return ({1'b0, cnt} + 33'h000000001) >= {1'b0, target};
    endfunction

    function automatic logic pick_source(
        input logic [12:0] sel,
        input logic relay,
        input logic running,
        input logic charged,
        input logic [(1<<PTR_W)-1:0] bits
    );
        logic res;
        res = 1'b0;
        case (sel[2:0])
            edge_counter_pkg::SRC_RELAY_ONE: res = relay; // [R12]
            edge_counter_pkg::SRC_RUNNING: res = running; // [R12]
            edge_counter_pkg::SRC_CHARGED: res = charged; // [R12]
            edge_counter_pkg::SRC_CONST_LOW: res = 1'b0; // [R10]
            edge_counter_pkg::SRC_CONST_HIGH: res = 1'b1; // [R10]
            edge_counter_pkg::SRC_POINTER:
                res = bits[sel[edge_counter_pkg::SRC_PTR_LSB +: PTR_W]]; // [R10]
            default: res = 1'b0;
        endcase
        return res;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic do_write;
        logic hit_region;
        logic idx;
        logic [7:0] off;
        logic [31:0] merged;
        logic [1:0] clear_value;
        logic [1:0] irq_clear;
        logic [31:0] base;
        logic bump;
        logic [31:0] rd;
        logic rd_ok;
        logic ridx;
        logic [7:0] roff;
        do_write = 1'b0;
        hit_region = 1'b0;
        idx = 1'b0;
        off = 8'h00;
        merged = 32'h00000000;
        clear_value = 2'h0;
        irq_clear = 2'h0;
        base = 32'h00000000;
        bump = 1'b0;
        rd = 32'h00000000;
        rd_ok = 1'b1;
        ridx = 1'b0;
        roff = 8'h00;
        next_s = s;

        // write address and data, taken in either order
        if (s_axi_awvalid && s.awready) begin
            next_s.aw_full = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.w_full = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        do_write = s.aw_full && s.w_full && !s.bvalid;
        if (do_write) begin
            next_s.aw_full = 1'b0;
            next_s.w_full = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = edge_counter_pkg::RESP_OKAY;
            hit_region = s.aw_addr < edge_counter_pkg::OFF_STATUS;
            idx = s.aw_addr[edge_counter_pkg::CNT_SEL_BIT];
            off = s.aw_addr & edge_counter_pkg::CNT_OFF_MASK;
            if (hit_region) begin
                case ({off[7:2], 2'h0})
                    edge_counter_pkg::OFF_FUNC: begin
                        merged = merge_bytes({30'h0, s.func[idx]},
                            s.w_data, s.w_strb);
                        next_s.func[idx] = merged[1:0];
                    end
                    edge_counter_pkg::OFF_SRC: begin
                        merged = merge_bytes({19'h0, s.src[idx]},
                            s.w_data, s.w_strb);
                        next_s.src[idx] = merged[12:0];
                    end
                    edge_counter_pkg::OFF_LIMIT: begin
                        merged = merge_bytes({1'b0, s.limit[idx]},
                            s.w_data, s.w_strb);
                        next_s.limit[idx] = merged[30:0]; // [R4]
                    end
                    edge_counter_pkg::OFF_DIV: begin
                        merged = merge_bytes({1'b0, s.divisor[idx]},
                            s.w_data, s.w_strb);
                        // zero would bump the count on every edge, as 1 does
                        next_s.divisor[idx] =
                            (merged[30:0] < edge_counter_pkg::DIV_MIN) ?
                            edge_counter_pkg::DIV_MIN : merged[30:0]; // [R2]
                    end
                    edge_counter_pkg::OFF_CHOICE: begin
                        merged = merge_bytes({29'h0, s.choice[idx]},
                            s.w_data, s.w_strb);
                        // codes above the last identity are ignored
                        if (merged[31:0] <=
                            {29'h0, edge_counter_pkg::ALARM_LINK_CHARGE}) begin
                            next_s.choice[idx] = merged[2:0]; // [R5]
                        end
                    end
                    edge_counter_pkg::OFF_VALUE: begin
                        clear_value[idx] = 1'b1; // [R6]
                    end
                    default: next_s.bresp = edge_counter_pkg::RESP_SLVERR;
                endcase
            end else begin
                case ({s.aw_addr[7:2], 2'h0})
                    edge_counter_pkg::OFF_IRQ_CLEAR: begin
                        if (s.w_strb[0]) begin
                            irq_clear = s.w_data[1:0];
                        end
                    end
                    edge_counter_pkg::OFF_IRQ_ENABLE: begin
                        if (s.w_strb[0]) begin
                            next_s.irq_enable = s.w_data[1:0];
                        end
                    end
                    edge_counter_pkg::OFF_STATUS,
                    edge_counter_pkg::OFF_IRQ_STATUS: begin
                        next_s.bresp = edge_counter_pkg::RESP_OKAY;
                    end
                    default: next_s.bresp = edge_counter_pkg::RESP_SLVERR;
                endcase
            end
        end
        next_s.awready = !next_s.aw_full && !next_s.bvalid;
        next_s.wready = !next_s.w_full && !next_s.bvalid;

        // clearing the value also drops the passed-limit flag
        next_s.exceeded = s.exceeded & ~clear_value;
        next_s.irq_status = s.irq_status & ~irq_clear;

        // counters
        for (int i = 0; i < 2; i++) begin
            next_s.sample[i] = pick_source(s.src[i], relay_one_state,
                drive_running, circuit_charged, monitored_bits); // [R13]
            next_s.prev[i] = s.sample[i]; // [R13]
            base = clear_value[i] ? 32'h00000000 : s.value[i]; // [R6]
            next_s.value[i] = base;
            if (clear_value[i]) begin
                next_s.prescale[i] = 31'h00000000;
            end
            bump = 1'b0;

            // alarm timing
            case (s.alarm_state[i])
                edge_counter_pkg::ALARM_IDLE: begin
                    next_s.alarm_out[i] = 1'b0;
                end
                edge_counter_pkg::ALARM_TIMED: begin
                    if (s.hold[i] == 32'h00000000) begin
                        next_s.alarm_state[i] = edge_counter_pkg::ALARM_IDLE;
                        next_s.alarm_out[i] = 1'b0; // [R9]
                    end else begin
                        next_s.hold[i] = s.hold[i] - 32'h00000001; // [R14]
                    end
                end
                edge_counter_pkg::ALARM_LATCHED: begin
                    next_s.alarm_out[i] = 1'b1; // [R9]
                end
                default: begin
                    next_s.alarm_state[i] = edge_counter_pkg::ALARM_IDLE;
                    next_s.alarm_out[i] = 1'b0;
                end
            endcase

            // an event in the clearing cycle still counts after the clear
            if (s.sample[i] && !s.prev[i]) begin // [R1] [R13]
                if (reaches({1'b0, s.prescale[i]},
                    {1'b0, s.divisor[i]})) begin // [R2]
                    next_s.prescale[i] = 31'h00000000;
                    bump = 1'b1;
                end else begin
                    next_s.prescale[i] = s.prescale[i] + 31'h00000001;
                end
            end
            if (bump) begin
                if (reaches(base, {1'b0, s.limit[i]})) begin // [R3] [R4]
                    next_s.value[i] = 32'h00000000; // [R3]
                    // set beats any clear in the same cycle
                    next_s.exceeded[i] = 1'b1; // [R7] [R11]
                    next_s.irq_status[i] = 1'b1;
                    if (s.func[i][edge_counter_pkg::FUNC_ENABLE_BIT]) begin // [R8]
                        next_s.alarm_out[i] = 1'b1; // [R3]
                        next_s.alarm_id[i] = s.choice[i]; // [R5]
                        if (s.func[i][edge_counter_pkg::FUNC_LATCH_BIT]) begin
                            next_s.alarm_state[i] =
                                edge_counter_pkg::ALARM_LATCHED; // [R9]
                        end else if (s.alarm_state[i] !=
                            edge_counter_pkg::ALARM_LATCHED) begin
                            next_s.alarm_state[i] =
                                edge_counter_pkg::ALARM_TIMED; // [R9]
                            next_s.hold[i] = HOLD_LOAD; // [R14]
                        end
                    end
                end else begin
                    next_s.value[i] = base + 32'h00000001;
                end
            end
        end
        next_s.irq = |(next_s.irq_status & next_s.irq_enable);

        // read channel
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
            next_s.arready = 1'b1;
        end
        if (s_axi_arvalid && s.arready) begin
            ridx = s_axi_araddr[edge_counter_pkg::CNT_SEL_BIT];
            roff = s_axi_araddr & edge_counter_pkg::CNT_OFF_MASK;
            if (s_axi_araddr < edge_counter_pkg::OFF_STATUS) begin
                case ({roff[7:2], 2'h0})
                    edge_counter_pkg::OFF_FUNC: rd = {30'h0, s.func[ridx]};
                    edge_counter_pkg::OFF_SRC: rd = {19'h0, s.src[ridx]};
                    edge_counter_pkg::OFF_LIMIT: rd = {1'b0, s.limit[ridx]};
                    edge_counter_pkg::OFF_DIV: rd = {1'b0, s.divisor[ridx]};
                    edge_counter_pkg::OFF_CHOICE: rd = {29'h0, s.choice[ridx]};
                    edge_counter_pkg::OFF_VALUE: rd = s.value[ridx]; // [R6]
                    default: rd_ok = 1'b0;
                endcase
            end else begin
                case ({s_axi_araddr[7:2], 2'h0})
                    edge_counter_pkg::OFF_STATUS: begin
                        rd[edge_counter_pkg::STATUS_ALARM_A_BIT] =
                            s.alarm_out[0];
                        rd[edge_counter_pkg::STATUS_ALARM_B_BIT] =
                            s.alarm_out[1];
                        rd[edge_counter_pkg::STATUS_EXCEEDED_A_BIT] =
                            s.exceeded[0]; // [R11]
                        rd[edge_counter_pkg::STATUS_EXCEEDED_B_BIT] =
                            s.exceeded[1]; // [R7]
                    end
                    edge_counter_pkg::OFF_IRQ_STATUS:
                        rd = {30'h0, s.irq_status};
                    edge_counter_pkg::OFF_IRQ_CLEAR: rd = 32'h00000000;
                    edge_counter_pkg::OFF_IRQ_ENABLE:
                        rd = {30'h0, s.irq_enable};
                    default: rd_ok = 1'b0;
                endcase
            end
            next_s.rdata = rd;
            next_s.rresp = rd_ok ? edge_counter_pkg::RESP_OKAY :
                edge_counter_pkg::RESP_SLVERR;
            next_s.rvalid = 1'b1;
            next_s.arready = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '0;
            for (int i = 0; i < 2; i++) begin
                s.func[i] <= edge_counter_pkg::FUNC_RESET;
                s.src[i] <= edge_counter_pkg::SRC_RESET;
                s.limit[i] <= edge_counter_pkg::LIMIT_RESET;
                s.divisor[i] <= edge_counter_pkg::DIV_RESET;
                s.alarm_state[i] <= edge_counter_pkg::ALARM_IDLE; // [R9]
            end
            s.awready <= 1'b1;
            s.wready <= 1'b1;
            s.arready <= 1'b1;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bresp = s.bresp;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_arready = s.arready;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rvalid = s.rvalid;
    assign alarm_a_active = s.alarm_out[0];
    assign alarm_a_id = s.alarm_id[0];
    assign alarm_b_active = s.alarm_out[1];
    assign alarm_b_id = s.alarm_id[1];
    assign irq = s.irq;

endmodule

`default_nettype wire

//--- testbench/edge_counter_properties.sv
// assertions on the bus handshakes and alarm outputs of the counter pair
`timescale 1ns/1ps
`default_nettype none
module edge_counter_properties (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic alarm_a_active,
    input wire logic [2:0] alarm_a_id,
    input wire logic alarm_b_active,
    input wire logic [2:0] alarm_b_id
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ce low freezes every flop, so a take only counts with ce high
    sequence s_rd_take; s_axi_arvalid && s_axi_arready && ce; endsequence
    sequence s_b_take; s_axi_bvalid && s_axi_bready && ce; endsequence
    property p_rd_answer; s_rd_take |=> s_axi_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read late");
    property p_rd_done;
        s_axi_rvalid && s_axi_rready && ce |=> !s_axi_rvalid;
    endproperty
    a_rd_done: assert property (p_rd_done) else $error("rvalid stuck");
    property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("arready early");
    property p_wr_done; s_b_take |=> !s_axi_bvalid && s_axi_awready; endproperty
    a_wr_done: assert property (p_wr_done) else $error("write end bad");
    property p_wr_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_wr_block: assert property (p_wr_block) else $error("ready early");
    property p_id_a; $rose(alarm_a_active) |-> alarm_a_id <= 3'h5; endproperty
    a_id_a: assert property (p_id_a) else $error("bad alarm a id");
    property p_id_b; $rose(alarm_b_active) |-> alarm_b_id <= 3'h5; endproperty
    a_id_b: assert property (p_id_b) else $error("bad alarm b id");
    property p_id_keep; $fell(alarm_a_active) |-> $stable(alarm_a_id); endproperty
    a_id_keep: assert property (p_id_keep) else $error("id lost");
endmodule
`default_nettype wire

//--- testbench/rising_edge_event_counter_tb.sv
// self-checking bench for the rising-edge event counter pair
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module rising_edge_event_counter_tb;
    logic clk, reset, ce, edge_a, relay_one_state, drive_running, irq;
    logic circuit_charged, alarm_a_active, alarm_b_active, s_axi_awvalid;
    logic s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, exp_b;
    logic [2:0] alarm_a_id, alarm_b_id;
    logic [3:0] s_axi_wstrb;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, monitored_bits, lim;
    // seeded here so the noise process stays its only driver
    logic [31:0] seed = 32'h1429A4D7;
    logic [33:0] exp_r;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    int num_errors = 0;
    int total_checks = 0;
    localparam logic [7:0] CA = edge_counter_pkg::CNT_A_BASE;
    localparam logic [7:0] CB = edge_counter_pkg::CNT_B_BASE;
    rising_edge_event_counter #(.ALARM_HOLD_CYCLES(20)) dut_u (.*);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // noise on relay one, circuit charged and the other monitored bits catches a wrong mux choice
    always @(posedge clk) begin
        seed <= xs(seed);
        {relay_one_state, circuit_charged} <= seed[1:0];
        monitored_bits <= {seed[31:8], edge_a, seed[6:0]};
    end
    always @(posedge clk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            exp_b = bq.pop_front();
            `CHK(s_axi_bresp, exp_b)
        end
        if (s_axi_rvalid && s_axi_rready) begin
            exp_r = rq.pop_front();
            `CHK({s_axi_rresp, s_axi_rdata}, exp_r)
        end
    end
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic hang(input int n);
        if (n == 50) begin
            num_errors++;
            summarize();
        end
    endtask
    // bready and rready stay high, so answers are never stalled here
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        bq.push_back(2'h0);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        hang(n);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        int n;
        rq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        hang(n);
    endtask
    task automatic edges(input logic b, input int n);
        repeat (2 * n) begin
            if (b) drive_running <= !drive_running;
            else edge_a <= !edge_a;
            repeat (2) @(posedge clk);
        end
        repeat (2) @(posedge clk);
    endtask
    initial begin
        {ce, reset, s_axi_bready, s_axi_rready, s_axi_wstrb} = 8'hFF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, edge_a} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, drive_running} = '0;
        repeat (3) @(posedge clk);
        reset <= 0;
        @(posedge clk);
        rd(CA + 8'h08, {2'h0, 32'h7FFFFFFF});
        rd(CA + 8'h18, {2'h2, 32'h0});
        lim = seed;
        wr(CA + 8'h08, lim);
        rd(CA + 8'h08, {3'h0, lim[30:0]});
        wr(CA + 8'h04, 32'h0705);
        wr(CA + 8'h0C, 32'h2);
        wr(CA + 8'h08, 32'h3);
        wr(CA + 8'h10, 32'h5);
        wr(CA + 8'h10, 32'h7);
        wr(CA, 32'h2);
        wr(8'h4C, 32'h1);
        wr(CA + 8'h14, 32'h0);
        edges(0, 5);
        rd(CA + 8'h14, {2'h0, 32'h2});
        edges(0, 1);
        `CHK({alarm_a_active, alarm_a_id, irq}, 5'h1B)
        rd(8'h40, {2'h0, 32'h5});
        repeat (25) @(posedge clk);
        `CHK(alarm_a_active, 1'b0)
        wr(8'h48, 32'h1);
        @(posedge clk);
        `CHK(irq, 1'b0)
        wr(CA + 8'h14, 32'h0);
        wr(CA, 32'h0);
        edges(0, 6);
        `CHK({alarm_a_active, irq}, 2'h1)
        rd(8'h40, {2'h0, 32'h4});
        wr(CA + 8'h0C, 32'h1);
        wr(CA + 8'h04, 32'h3);
        wr(CA + 8'h04, 32'h4);
        // the constant's step lands two edges after the write
        repeat (2) @(posedge clk);
        rd(CA + 8'h14, {2'h0, 32'h1});
        wr(CB + 8'h04, 32'h1);
        wr(CB, 32'h3);
        wr(CB + 8'h10, 32'h1);
        wr(CB + 8'h14, 32'h0);
        edges(1, 3);
        rd(CB + 8'h14, {2'h0, 32'h3});
        // edges while ce is low must not be counted
        ce <= 0;
        edges(1, 2);
        ce <= 1;
        rd(CB + 8'h14, {2'h0, 32'h3});
        wr(CB + 8'h14, 32'h0);
        wr(CB + 8'h08, 32'h2);
        edges(1, 2);
        `CHK({alarm_b_active, alarm_b_id}, 4'h9)
        repeat (30) @(posedge clk);
        `CHK(alarm_b_active, 1'b1)
        rd(8'h40, {2'h0, 32'hE});
        summarize();
    end
endmodule
bind rising_edge_event_counter edge_counter_properties chk_u (.*);
`default_nettype wire
